// ---- src/tmf_pkg.sv ----
// package with register map, field encodings and timing constants for the test mode block
package tmf_pkg;

  // channel counts
  localparam int unsigned N_CIN      = 16;             // contact inputs
  localparam int unsigned N_COUT     = 16;             // contact outputs
  localparam int unsigned N_SOFT_IN  = 64;             // virtual inputs
  localparam int unsigned N_SOFT_OUT = 96;             // virtual outputs
  localparam int unsigned N_REMOTE   = 32;             // remote inputs
  localparam int unsigned N_TELE     = 16;             // teleprotection inputs per channel

  // register byte offsets
  localparam logic [7:0] REG_CTRL        = 8'h00;      // enable and initiate select
  localparam logic [7:0] REG_STATUS      = 8'h04;      // test mode state
  localparam logic [7:0] REG_IN_FORCE    = 8'h08;      // input_force_setting, 2 bits per input
  localparam logic [7:0] REG_OUT_FORCE   = 8'h0C;      // output_force_setting, 2 bits per output
  localparam logic [7:0] REG_CIN_STAT    = 8'h10;      // reported contact_in_point states
  localparam logic [7:0] REG_COUT_STAT   = 8'h14;      // contact_out_point states
  localparam logic [7:0] REG_SOFT_IN_LO  = 8'h18;      // soft_input_point 31..0
  localparam logic [7:0] REG_SOFT_IN_HI  = 8'h1C;      // soft_input_point 63..32
  localparam logic [7:0] REG_SOFT_OUT_0  = 8'h20;      // soft_output_point 31..0
  localparam logic [7:0] REG_SOFT_OUT_1  = 8'h24;      // soft_output_point 63..32
  localparam logic [7:0] REG_SOFT_OUT_2  = 8'h28;      // soft_output_point 95..64
  localparam logic [7:0] REG_REMOTE_STAT = 8'h2C;      // remote input states
  localparam logic [7:0] REG_REMOTE_DFLT = 8'h30;      // remote input default states
  localparam logic [7:0] REG_TELE_STAT   = 8'h34;      // ch1 in 15..0, ch2 in 31..16
  localparam logic [7:0] REG_DET_LO      = 8'h38;      // detector codes outputs 7..0
  localparam logic [7:0] REG_DET_HI      = 8'h3C;      // detector codes outputs 15..8

  // control register fields
  localparam int unsigned CTRL_EN_BIT  = 0;            // test function enable
  localparam int unsigned CTRL_SEL_BIT = 1;            // 0: initiate constant on, 1: operand
  localparam int unsigned STAT_ACT_BIT = 0;            // test mode active

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;    // all settings disabled

  // input forcing encodings
  localparam logic [1:0] INF_DISABLED = 2'h0;          // follow terminals
  localparam logic [1:0] INF_OPEN     = 2'h1;          // report zero
  localparam logic [1:0] INF_CLOSED   = 2'h2;          // report one

  // output forcing encodings
  localparam logic [1:0] OUTF_DISABLED = 2'h0;         // follow operand
  localparam logic [1:0] OUTF_ENERGIZE = 2'h1;         // hold closed
  localparam logic [1:0] OUTF_DEENERGY = 2'h2;         // hold open
  localparam logic [1:0] OUTF_FREEZE   = 2'h3;         // hold pre-test state

  // detector status codes, bit 2 is the on/off state
  localparam logic [3:0] DET_OFF  = 4'h0;
  localparam logic [3:0] DET_VOLTAGE_DETECT_OFF = 4'h1;
  localparam logic [3:0] DET_CURRENT_DETECT_OFF = 4'h2;
  localparam logic [3:0] DET_ON   = 4'h4;
  localparam logic [3:0] DET_VON  = 4'h5;
  localparam logic [3:0] DET_ION  = 4'h6;

  // outputs fitted with voltage and current detectors
  localparam logic [15:0] FORM_A_MASK = 16'h00FF;

  // indicator flash timing
  localparam int unsigned CLK_HZ        = 100_000_000;                  // system clock rate
  localparam int unsigned BLINK_HALF_MS = 250;                          // on or off phase
  localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;

endpackage : tmf_pkg

// ---- src/tmf_top.sv ----
// test mode control with contact forcing and binary point status, reached over apb
// test mode is a plain level
// active flag lags one cycle
// forcing lags it one more
// freeze image taken on entry
// soft points never forced
// remote points never forced
//
// apb: one wait state
// answers stand one cycle
// write lands on ready edge
// unmapped: error, zero data
// read-only: write dropped
// strobes merge byte lanes
//
// lamp lit on entry
// lamp may glow a cycle after exit
// outputs 0 to 7 have detectors
// voltage wins over current
// reset clears all forcing
// one means on, zero off
// soft inputs set by software
// soft outputs lag a cycle
//
// register map
// 00 control
// 04 status
// 08 input forcing
// 0c output forcing
// 10 contact inputs
// 14 contact outputs
// 18 soft inputs lo
// 1c soft inputs hi
// 20 soft outputs 0
// 24 soft outputs 1
// 28 soft outputs 2
// 2c remote inputs
// 30 remote defaults
// 34 tele inputs
// 38 detectors lo
// 3c detectors hi
//
// input forcing: 0 off,
// 1 open, 2 closed
// output forcing: 0 off,
// 1 energize, 2 de-energize,
// 3 freeze
//
// detector codes: 0 off,
// 1 voltage off, 2 current off,
// 4 on, 5 voltage on,
// 6 current on
//
// a lamp that stops flashing
// means the divider is stuck
`timescale 1ns/1ps

module tmf_top
  import tmf_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYC   // half period of the indicator flash
) (
  input  wire logic                  i_sys_clk,          // system clock
  input  wire logic                  i_sys_rst,          // synchronous reset, active high

  // apb slave
  // one word per register
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [7:0]            i_paddr,
  input  wire logic [31:0]           i_pwdata,
  input  wire logic [3:0]            i_pstrb,
  output logic                       o_pready,
  output logic                       o_pslverr,
  output logic [31:0]                o_prdata,

  // test initiation
  input  wire logic                  i_test_operand,     // selectable logic operand
  output logic                       o_test_active,      // test mode state
  output logic                       o_test_led,         // flashing indicator

  // contacts
  input  wire logic [N_CIN-1:0]      i_contact_in,       // sensed terminal states
  output logic      [N_CIN-1:0]      o_contact_in_point, // reported contact inputs
  input  wire logic [N_COUT-1:0]     i_out_operand,      // control operands
  output logic      [N_COUT-1:0]     o_contact_out,      // relay drive, one closes
  input  wire logic [N_COUT-1:0]     i_volt_det,         // voltage detectors
  input  wire logic [N_COUT-1:0]     i_curr_det,         // current detectors

  // soft points
  output logic      [N_SOFT_IN-1:0]  o_soft_in,          // virtual input states
  input  wire logic [N_SOFT_OUT-1:0] i_soft_out_eq,      // logic equation results

  // remote and teleprotection points
  input  wire logic [N_REMOTE-1:0]   i_remote_state,     // received remote states
  input  wire logic [N_REMOTE-1:0]   i_remote_online,    // source device online per input
  output logic      [N_REMOTE-1:0]   o_remote_in,        // resolved remote inputs
  input  wire logic [N_TELE-1:0]     i_tele_rx_ch1,      // received remote outputs ch1
  input  wire logic [N_TELE-1:0]     i_tele_rx_ch2,      // received remote outputs ch2
  input  wire logic [1:0]            i_tele_fail,        // channel declared failed
  output logic      [2*N_TELE-1:0]   o_tele_in           // ch2 high half, ch1 low half
);

  // one struct, one reset
  // the whole state of the block
  typedef struct packed {
    // settings
    logic                  test_en;      // test function enable
    logic                  init_sel;     // initiate source select
    logic                  test_active;  // test mode
    logic [31:0]           in_force;     // 2 bits per contact input
    logic [31:0]           out_force;    // 2 bits per contact output

    // resolved points
    logic [N_CIN-1:0]      cin;          // reported contact inputs
    logic [N_COUT-1:0]     cout;         // contact output drive
    logic [N_COUT-1:0]     frozen;       // state captured at test entry
    logic [N_SOFT_IN-1:0]  soft_in;      // virtual inputs
    logic [N_SOFT_OUT-1:0] soft_out;     // virtual outputs
    logic [N_REMOTE-1:0]   remote_dflt;  // programmed remote defaults
    logic [N_REMOTE-1:0]   remote;       // resolved remote inputs
    logic [2*N_TELE-1:0]   tele;         // resolved teleprotection inputs
    logic [4*N_COUT-1:0]   det;          // detector status codes

    // lamp and bus answer
    logic [31:0]           blink_cnt;    // flash divider
    logic                  led;          // indicator
    logic                  pready;       // apb ready
    logic                  pslverr;      // apb error
    logic [31:0]           prdata;       // apb read data
  } tmf_state_t;

  // held and next state
  tmf_state_t st;                        // registered state
  tmf_state_t next_st;                   // next state

  // per-channel slices
  logic [N_CIN-1:0]    next_cin;         // per-input resolved value
  logic [N_COUT-1:0]   next_cout;        // per-output resolved value
  logic [4*N_COUT-1:0] next_det;         // per-output detector code

  // per-channel forcing and detector encoding
  // reads the registered flag
  // so forcing starts cleanly
  genvar k;
  generate
    for (k = 0; k < N_CIN; k++) begin : g_cin
      logic [1:0] f;                     // this input's forcing
      assign f = st.in_force[2*k +: 2];
      // forcing only in test
      always_comb begin
        if (st.test_active && f == INF_OPEN) begin
          next_cin[k] = 1'b0;
        end else if (st.test_active && f == INF_CLOSED) begin
          next_cin[k] = 1'b1;
        end else begin
          next_cin[k] = i_contact_in[k];
        end
      end
    end

    // outputs, then detectors
    for (k = 0; k < N_COUT; k++) begin : g_cout
      logic [1:0] f;                     // this output's forcing
      logic       on;                    // resulting contact state
      assign f = st.out_force[2*k +: 2];
      // freeze wins in test only
      always_comb begin
        on = i_out_operand[k];
        if (st.test_active) begin
          unique case (f)
            OUTF_ENERGIZE: on = 1'b1;
            OUTF_DEENERGY: on = 1'b0;
            OUTF_FREEZE:   on = st.frozen[k];
            OUTF_DISABLED: on = i_out_operand[k];
          endcase
        end
        next_cout[k] = on;
        // voltage detector takes precedence when both see activity
        if (!FORM_A_MASK[k]) begin
          next_det[4*k +: 4] = on ? DET_ON : DET_OFF;
        end else if (i_volt_det[k]) begin
          next_det[4*k +: 4] = on ? DET_VON : DET_VOLTAGE_DETECT_OFF;
        end else if (i_curr_det[k]) begin
          next_det[4*k +: 4] = on ? DET_ION : DET_CURRENT_DETECT_OFF;
        end else begin
          next_det[4*k +: 4] = on ? DET_ON : DET_OFF;
        end
      end
    end
  endgenerate

  // byte-lane merge for apb writes
  // unstrobed lanes keep value
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge_lanes

  // helpers of the process
  logic        initiate;                 // initiate condition
  logic        acc_first;                // first access cycle, ready not yet given
  logic        acc_done;                 // completing edge of a transfer
  logic        addr_ok;                  // address is mapped
  logic [31:0] rd_word;                  // read mux result
  logic [31:0] wr_word;                  // merged write value

  // next-state logic
  // fields default to held
  always_comb begin
    next_st  = st;
    rd_word  = RST_WORD;
    addr_ok  = 1'b1;
    wr_word  = RST_WORD;

    // test mode: a constant initiate makes the enable's rise the entry point,
    // an operand initiate makes the operand's rise the entry point
    initiate = st.init_sel ? i_test_operand : 1'b1;
    next_st.test_active = st.test_en & initiate;

    // capture the contact states on the very edge test mode begins
    // image from unforced flops
    // each entry takes a new one
    for (int i = 0; i < N_COUT; i++) begin
      if (!st.test_active && next_st.test_active) begin
        next_st.frozen[i] = st.cout[i];
      end
    end

    // forced and normal contact paths; everything else bypasses forcing
    // soft outputs lag a cycle
    next_st.cin  = next_cin;
    next_st.cout = next_cout;
    next_st.det  = next_det;
    next_st.soft_out = i_soft_out_eq;

    // remote inputs fall back to their defaults while offline
    // one online flag per input
    for (int i = 0; i < N_REMOTE; i++) begin
      next_st.remote[i] = i_remote_online[i] ? i_remote_state[i] : st.remote_dflt[i];
    end

    // teleprotection inputs read off while the channel is failed
    // failed channel reads off
    next_st.tele[N_TELE-1:0]        = i_tele_fail[0] ? '0 : i_tele_rx_ch1;
    next_st.tele[2*N_TELE-1:N_TELE] = i_tele_fail[1] ? '0 : i_tele_rx_ch2;

    // indicator flash: the divider runs only in test mode so the led starts lit
    // rate set by the parameter
    if (st.test_active) begin
      if (st.blink_cnt >= BLINK_CYCLES - 1) begin
        next_st.blink_cnt = 32'h0000_0000;
        next_st.led       = ~st.led;
      end else begin
        next_st.blink_cnt = st.blink_cnt + 32'h0000_0001;
      end
    end else begin
      next_st.blink_cnt = 32'h0000_0000;
      next_st.led       = next_st.test_active;
    end

    // read mux, one on means logic one
    // unused bits read zero
    // status words lag a cycle
    unique case (i_paddr)
      REG_CTRL: begin
        rd_word[CTRL_EN_BIT]  = st.test_en;
        rd_word[CTRL_SEL_BIT] = st.init_sel;
      end
      REG_STATUS:      rd_word[STAT_ACT_BIT] = st.test_active;
      REG_IN_FORCE:    rd_word = st.in_force;
      REG_OUT_FORCE:   rd_word = st.out_force;
      REG_CIN_STAT:    rd_word[N_CIN-1:0] = st.cin;
      REG_COUT_STAT:   rd_word[N_COUT-1:0] = st.cout;
      REG_SOFT_IN_LO:  rd_word = st.soft_in[31:0];
      REG_SOFT_IN_HI:  rd_word = st.soft_in[63:32];
      REG_SOFT_OUT_0:  rd_word = st.soft_out[31:0];
      REG_SOFT_OUT_1:  rd_word = st.soft_out[63:32];
      REG_SOFT_OUT_2:  rd_word = st.soft_out[95:64];
      REG_REMOTE_STAT: rd_word = st.remote;
      REG_REMOTE_DFLT: rd_word = st.remote_dflt;
      REG_TELE_STAT:   rd_word = st.tele;
      REG_DET_LO:      rd_word = st.det[31:0];
      REG_DET_HI:      rd_word = st.det[63:32];
      default:         addr_ok = 1'b0;
    endcase

    // apb: one wait state, ready and data come from flops
    // first cycle arms ready
    // second cycle shows it
    acc_first = i_psel & i_penable & ~st.pready;
    acc_done  = i_psel & i_penable & st.pready;
    next_st.pready  = acc_first;
    next_st.pslverr = acc_first & ~addr_ok;
    next_st.prdata  = (acc_first && !i_pwrite && addr_ok) ? rd_word : RST_WORD;

    // writes land on the edge where the master sees ready
    // request still held here
    // forcing may change in test
    wr_word = merge_lanes(rd_word, i_pwdata, i_pstrb);
    if (acc_done && i_pwrite) begin
      unique case (i_paddr)
        REG_CTRL: begin
          next_st.test_en  = wr_word[CTRL_EN_BIT];
          next_st.init_sel = wr_word[CTRL_SEL_BIT];
        end
        REG_IN_FORCE:    next_st.in_force = wr_word;
        REG_OUT_FORCE:   next_st.out_force = wr_word;
        REG_SOFT_IN_LO:  next_st.soft_in[31:0] = wr_word;
        REG_SOFT_IN_HI:  next_st.soft_in[63:32] = wr_word;
        REG_REMOTE_DFLT: next_st.remote_dflt = wr_word;
        default: begin
          // read-only or unmapped words ignore writes
        end
      endcase
    end
  end

  // state register
  // reset clears settings too
  // every field loads each clock
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  // no logic after the flops
  assign o_pready           = st.pready;
  assign o_pslverr          = st.pslverr;
  assign o_prdata           = st.prdata;
  assign o_test_active      = st.test_active;
  assign o_test_led         = st.led;
  assign o_contact_in_point = st.cin;
  assign o_contact_out      = st.cout;
  assign o_soft_in          = st.soft_in;
  assign o_remote_in        = st.remote;
  assign o_tele_in          = st.tele;

endmodule : tmf_top

// ---- test/test_tmf_top.sv ----
// self-checking bench for the test mode block with a field wiring model
`timescale 1ns/1ps

module test_tmf_top;
  import tmf_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr, t_op = 0, act, led, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 0, prdata, rd, w, x, fin, fout, rem_s = 0, rem_on = 0, rem_in, tele_in;
  logic [15:0] fv = 0, opnd = 0, cin, cin_pt, cout, vdet, cdet, wet = 0, load = 0, t1 = 0, t2 = 0, fr;
  logic [1:0]  tfail = 0;
  logic [63:0] soft_in, dx;
  logic [95:0] soft_eq = 0;
  int          fail_count = 0, n_compared = 0, k;

  always #5 clk = ~clk;  // 100 MHz

  tmf_top #(.BLINK_CYCLES(4)) u_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_test_operand(t_op), .o_test_active(act), .o_test_led(led), .i_contact_in(cin),
    .o_contact_in_point(cin_pt), .i_out_operand(opnd), .o_contact_out(cout), .i_volt_det(vdet),
    .i_curr_det(cdet), .o_soft_in(soft_in), .i_soft_out_eq(soft_eq), .i_remote_state(rem_s),
    .i_remote_online(rem_on), .o_remote_in(rem_in), .i_tele_rx_ch1(t1), .i_tele_rx_ch2(t2),
    .i_tele_fail(tfail), .o_tele_in(tele_in));
  tmf_field u_field (.i_contact_out(cout), .i_field_v(fv), .i_wet(wet), .i_load(load), .o_term(cin),
    .o_volt_det(vdet), .o_curr_det(cdet));

  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one apb transfer; holds the request until ready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      report_and_stop;
    end
    // taken mid-cycle, where the answer has settled
    rd = prdata;
    er = pslverr;
    @(posedge clk);
    psel <= 0; pen <= 0;
  endtask : apb

  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  // reported contact inputs: forcing bites only while test mode is active
  function automatic logic [15:0] exp_in(logic [31:0] f, logic [15:0] t, logic a);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = (!a || f[2*i+:2] == INF_DISABLED) ? t[i] : (f[2*i+:2] == INF_CLOSED);
    return r;
  endfunction : exp_in

  function automatic logic [15:0] exp_out(logic [31:0] f, logic [15:0] op, logic [15:0] frz, logic a);
    logic [15:0] r;
    logic [1:0]  c;
    for (int i = 0; i < 16; i++) begin
      c = f[2*i+:2];
      r[i] = (!a || c == OUTF_DISABLED) ? op[i] : (c == OUTF_ENERGIZE) ? 1'b1 : (c == OUTF_DEENERGY) ? 1'b0 : frz[i];
    end
    return r;
  endfunction : exp_out

  // detector codes: fitted outputs report voltage before current, others only on or off
  function automatic logic [63:0] exp_det(logic [15:0] o, logic [15:0] v, logic [15:0] c);
    logic [63:0] r;
    for (int i = 0; i < 16; i++) begin
      r[4*i+:4] = o[i] ? DET_ON : DET_OFF;
      if (FORM_A_MASK[i]) r[4*i+:4] = r[4*i+:4] | (v[i] ? DET_VOLTAGE_DETECT_OFF : c[i] ? DET_CURRENT_DETECT_OFF : 4'h0);
    end
    return r;
  endfunction : exp_det

  initial begin
    #900us;
    fail_count++;
    report_and_stop;
  end

  initial begin
    rd = $urandom(1608);
    repeat (10) @(posedge clk);
    rst <= 0;
    // reset values, an unmapped word and a write to a read-only word
    apb(0, REG_CTRL, 0);       check("ctrl", rd, RST_WORD);
    apb(0, REG_OUT_FORCE, 0);  check("out force", rd, RST_WORD);
    apb(0, 8'h40, 0);          check("unmapped", {er, rd}, {1'b1, 32'h0000_0000});
    apb(1, REG_STATUS, 1);     apb(0, REG_STATUS, 0); check("status ro", {er, rd}, 33'h0);
    $display("test reset_map done");
    // constant initiate, nothing forced
    @(posedge clk); fv <= $urandom; opnd <= $urandom;
    apb(1, REG_CTRL, 1); settle;
    check("active", act, 1);
    check("in unforced", cin_pt, fv);
    check("out unforced", cout, opnd);
    apb(0, REG_STATUS, 0); check("status on", rd, 1);
    apb(1, REG_CTRL, 0); settle; check("left", act, 0);
    $display("test unforced done");
    // every forcing code, operand initiate
    fin = 0; fout = 0;
    for (int i = 0; i < 16; i++) begin
      fin[2*i+:2] = i % 3;
      fout[2*i+:2] = i % 4;
    end
    apb(1, REG_IN_FORCE, fin); apb(1, REG_OUT_FORCE, fout); apb(1, REG_CTRL, 3); settle;
    check("no initiate", act, 0);
    fr = opnd;
    @(posedge clk); t_op <= 1; settle;
    check("operand entry", act, 1);
    for (k = 0; k < 4; k++) begin
      @(posedge clk); fv <= $urandom; opnd <= $urandom; settle;
      check("in forced", cin_pt, exp_in(fin, fv, 1));
      check("out forced", cout, exp_out(fout, opnd, fr, 1));
      apb(0, REG_CIN_STAT, 0); check("in stat", rd, {16'h0, exp_in(fin, fv, 1)});
    end
    @(posedge clk); soft_eq <= {$urandom, $urandom, $urandom}; settle;
    apb(0, REG_SOFT_OUT_1, 0); check("soft out in test", rd, soft_eq[63:32]);
    @(posedge clk); t_op <= 0; settle;
    check("release in", cin_pt, fv);
    check("release out", cout, opnd);
    apb(1, REG_IN_FORCE, 0); apb(1, REG_OUT_FORCE, 0);
    @(posedge clk); t_op <= 1; settle;
    check("cleared in", cin_pt, fv);
    @(posedge clk); t_op <= 0;
    $display("test forcing done");
    // status points
    @(posedge clk); wet <= $urandom; load <= $urandom; settle;
    dx = exp_det(opnd, wet & ~opnd, load & opnd);
    apb(0, REG_DET_LO, 0); check("det lo", rd, dx[31:0]);
    apb(0, REG_DET_HI, 0); check("det hi", rd, dx[63:32]);
    w = $urandom; x = $urandom;
    apb(1, REG_SOFT_IN_LO, w); apb(1, REG_SOFT_IN_HI, x); settle;
    check("soft in", soft_in, {x, w});
    apb(0, REG_SOFT_IN_HI, 0); check("soft in hi", rd, x);
    apb(0, REG_SOFT_OUT_0, 0); check("soft out 0", rd, soft_eq[31:0]);
    apb(0, REG_SOFT_OUT_2, 0); check("soft out 2", rd, soft_eq[95:64]);
    w = $urandom; apb(1, REG_REMOTE_DFLT, w);
    @(posedge clk); rem_s <= $urandom; rem_on <= $urandom; settle;
    check("remote", rem_in, (rem_s & rem_on) | (w & ~rem_on));
    apb(0, REG_REMOTE_STAT, 0); check("remote stat", rd, (rem_s & rem_on) | (w & ~rem_on));
    for (k = 0; k < 4; k++) begin
      @(posedge clk); tfail <= k; t1 <= $urandom; t2 <= $urandom; settle;
      check("tele", tele_in, {tfail[1] ? 16'h0 : t2, tfail[0] ? 16'h0 : t1});
    end
    $display("test status done");
    report_and_stop;
  end
endmodule : test_tmf_top

// ---- test/tmf_field.sv ----
// far-side model of the contact wiring: terminal voltages and output detectors
`timescale 1ns/1ps

module tmf_field (
  input  wire logic [15:0] i_contact_out, // relay drive, one closes
  input  wire logic [15:0] i_field_v,     // terminal voltages chosen by the bench
  input  wire logic [15:0] i_wet,         // wetting voltage present across the contact
  input  wire logic [15:0] i_load,        // load connected in series
  output logic      [15:0] o_term,        // sensed terminal levels
  output logic      [15:0] o_volt_det,    // voltage seen across the contact
  output logic      [15:0] o_curr_det     // current flowing through the contact
);
  // terminals follow the field, never the relay: forcing must not leak out here
  assign o_term     = i_field_v;
  // an open contact shows the wetting voltage, a closed one carries load current
  assign o_volt_det = ~i_contact_out & i_wet;
  assign o_curr_det = i_contact_out & i_load;
endmodule : tmf_field

// ---- test/tmf_top_checker.sv ----
// concurrent checks on the ports of the test mode block
`timescale 1ns/1ps

module tmf_top_checker #(
  parameter int unsigned BLINK_CYCLES = 4  // half period of the indicator flash
) (
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_test_active,
  input wire logic        o_test_led,
  input wire logic [15:0] i_contact_in,
  input wire logic [15:0] o_contact_in_point,
  input wire logic [15:0] i_out_operand,
  input wire logic [15:0] o_contact_out,
  input wire logic [31:0] i_remote_state,
  input wire logic [31:0] i_remote_online,
  input wire logic [31:0] o_remote_in,
  input wire logic [15:0] i_tele_rx_ch1,
  input wire logic [1:0]  i_tele_fail,
  input wire logic [15:0] o_tele_in_lo
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  int unsigned run_cnt; // cycles the indicator has held its level in test
  logic        led_q;   // indicator level one cycle back

  // count a steady indicator; a missing toggle lets the count grow past the half period
  always_ff @(posedge i_sys_clk) begin
    led_q <= o_test_led;
    if (i_sys_rst || !o_test_active || o_test_led != led_q) begin
      run_cnt <= 0;
    end else begin
      run_cnt <= run_cnt + 1;
    end
  end

  a_ready_in_access: assert property (o_pready |-> i_psel && i_penable) else $error("ready outside access");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("ready held too long");
  a_error_with_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  a_rdata_idle_zero: assert property (!o_pready |-> o_prdata == 32'h0000_0000) else $error("read data not zero");
  a_led_on_entry: assert property ($rose(o_test_active) |-> o_test_led) else $error("led dark on entry");
  a_led_dark_idle: assert property (!o_test_active && !$past(o_test_active) |-> !o_test_led) else $error("led lit");
  a_led_flashes: assert property (o_test_active |-> run_cnt <= BLINK_CYCLES) else $error("led not flashing");
  a_input_follows: assert property (!o_test_active |=> o_contact_in_point == $past(i_contact_in))
    else $error("contact input not following terminals");
  a_output_follows: assert property (!o_test_active |=> o_contact_out == $past(i_out_operand))
    else $error("contact output not following operand");
  a_remote_online: assert property (##1 ((o_remote_in ^ $past(i_remote_state)) & $past(i_remote_online)) == '0)
    else $error("online remote input wrong");
  a_tele_channel: assert property (##1 o_tele_in_lo == ($past(i_tele_fail[0]) ? 16'h0000 : $past(i_tele_rx_ch1)))
    else $error("teleprotection channel wrong");

  c_enter_test: cover property ($rose(o_test_active));
  c_leave_test: cover property ($fell(o_test_active));
  c_slave_error: cover property (o_pslverr);
  c_led_toggle: cover property (o_test_active && $fell(o_test_led));
endmodule : tmf_top_checker

bind tmf_top tmf_top_checker #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (.i_sys_clk, .i_sys_rst, .i_psel, .i_penable,
  .o_pready, .o_pslverr, .o_prdata, .o_test_active, .o_test_led, .i_contact_in, .o_contact_in_point,
  .i_out_operand, .o_contact_out, .i_remote_state, .i_remote_online, .o_remote_in, .i_tele_rx_ch1,
  .i_tele_fail, .o_tele_in_lo(o_tele_in[15:0]));
